// file: verilog/bcc_top.sv
`timescale 1ns/1ps
`include "bcc_consts.svh"

// Operation
// R1: Command F0h resets all control state and aborts bus activity.
// R2: Global reset completes within 525 ns of the ack falling edge.
// R3: Bus activity stops within 262.5 ns of the ack falling edge.
// R4: After global reset the read pointer selects the status register.
// R5: Global reset sets reset flag, clears busy and all result flags.
// R6: Global reset clears speed, active pullup, power down, strong pullup.
// R7: Global or power-on reset restores port timing and pullup defaults.
// R8: Global reset accepted any time, always acknowledged.
// R9: Command E1h plus code sets the read pointer to that register.
// R10: Pointer set overrides engine pointer moves, leaves bus activity alone.
// R11: Invalid pointer code is not acknowledged; command discarded.
// R12: Read pointer updates on rising SCL of the code's ack bit.
// R13: Valid codes C3h setup, F0h flags, E1h read data, B4h port.
// R14: Command D2h plus byte writes setup, effective at once.
// R15: Setup stored only if high nibble inverts low nibble.
// R16: Setup register reads zero in its upper four bits.
// R17: Busy at D2h arrival: command and parameter not acknowledged.
// R18: Host waits for busy zero before writing setup.
// R19: Setup updates on rising SCL of the parameter's ack bit.
// R20: After setup write, read pointer selects the setup register.
// R21: Setup write updates four bits and clears the reset flag.
// R22: Busy flag reads one while bus communication runs.
// R23: Command and parameter arrive in one write transfer, each acked.
module bcc_top
  import bcc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `BCC_SLAVE_ADDR  // Arbitrary default address
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  // Serial host pins
  input  wire logic           scl,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe,
  // Bus engine side
  input  wire logic           eng_busy,
  input  wire logic           eng_line_level,
  input  wire logic           eng_flags_we,
  input  wire bcc_eng_flags_t eng_flags,
  input  wire logic           eng_ptr_to_flags,
  input  wire logic [7:0]     eng_rx_byte,
  input  wire logic [3:0]     eng_port_code,
  output bcc_setup_t          setup,
  output logic                bus_abort,
  output logic                port_defaults
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  // Two-stage release so the deassertion is clean to sys_clk
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ------------------------------------------------------------
  // Pin edge detection
  // ------------------------------------------------------------
  logic scl_q_reg, sda_q_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl;
      sda_q_reg <= sda_in;
    end
  end

  // Start and stop are SDA edges while SCL stays high
  assign scl_rise  = scl & ~scl_q_reg;
  assign scl_fall  = ~scl & scl_q_reg;
  assign bus_start = scl & scl_q_reg & sda_q_reg & ~sda_in;
  assign bus_stop  = scl & scl_q_reg & ~sda_q_reg & sda_in;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic ptr_code_ok(input logic [7:0] code);
    ptr_code_ok = (code == `BCC_OFS_PORT) || (code == `BCC_OFS_SETUP) ||
                  (code == `BCC_OFS_RXBYTE) || (code == `BCC_OFS_FLAGS);  // [R13]
  endfunction
  function automatic logic cfg_code_ok(input logic [7:0] b);
    cfg_code_ok = (b[7:4] == ~b[3:0]);  // [R15]
  endfunction

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  bcc_state_t     state_reg,   state_next;
  bcc_act_t       act_reg,     act_next;
  logic [7:0]     shift_reg,   shift_next;
  logic [3:0]     bitcnt_reg,  bitcnt_next;
  logic [1:0]     bidx_reg,    bidx_next;
  logic [7:0]     cmd_reg,     cmd_next;
  logic           rd_reg,      rd_next;
  logic           ack_reg,     ack_next;
  logic [7:0]     ptr_reg,     ptr_next;
  bcc_setup_t     setup_reg,   setup_next;
  bcc_eng_flags_t flags_reg,   flags_next;
  logic           rstflg_reg,  rstflg_next;
  logic           busy_reg,    busy_next;
  logic           abort_reg,   abort_next;
  logic           sda_oe_reg,  sda_oe_next;
  logic [7:0]     rdata;
  // Byte presented to the host, chosen by the read pointer
  always_comb begin
    unique case (ptr_reg)
      `BCC_OFS_SETUP:  rdata = {4'h0, setup_reg};  // [R16]
      `BCC_OFS_RXBYTE: rdata = eng_rx_byte;
      `BCC_OFS_PORT:   rdata = {4'h0, eng_port_code};
      default:         rdata = {flags_reg.branch_dir, flags_reg.triplet_second_bit,
                                flags_reg.single_bit_result, rstflg_reg, eng_line_level,
                                flags_reg.short_seen_flag, flags_reg.presence_seen_flag,
                                busy_reg};
    endcase
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    act_next    = act_reg;
    shift_next  = shift_reg;
    bitcnt_next = bitcnt_reg;
    bidx_next   = bidx_reg;
    cmd_next    = cmd_reg;
    rd_next     = rd_reg;
    ack_next    = ack_reg;
    ptr_next    = ptr_reg;
    setup_next  = setup_reg;
    flags_next  = flags_reg;
    rstflg_next = rstflg_reg;
    busy_next   = eng_busy;  // [R22]
    abort_next  = 1'b0;
    sda_oe_next = sda_oe_reg;

    // Engine-side updates come first so host commands below take priority
    if (eng_flags_we) begin
      flags_next = eng_flags;
    end
    if (eng_ptr_to_flags) begin
      ptr_next = `BCC_OFS_FLAGS;
    end
    unique case (state_reg)
      ST_IDLE: begin
        sda_oe_next = 1'b0;
      end
      ST_RX: begin
        if (scl_rise) begin
          shift_next  = {shift_reg[6:0], sda_in};
          bitcnt_next = bitcnt_reg + 4'd1;
        end else if (scl_fall && bitcnt_reg == 4'd8) begin
          // Decide the acknowledge for the byte just received
          ack_next = 1'b0;
          act_next = ACT_NONE;
          unique case (bidx_reg)
            2'd0: begin
              ack_next = (shift_reg[7:1] == SLAVE_ADDR);
              rd_next  = shift_reg[0];
            end
            2'd1: begin
              cmd_next = shift_reg;
              if (shift_reg == `BCC_CMD_DEV_RESET) begin
                ack_next = 1'b1;                            // [R8]
                act_next = ACT_GRST;
              end else if (shift_reg == `BCC_CMD_SET_PTR) begin
                ack_next = 1'b1;                            // [R23]
              end else if (shift_reg == `BCC_CMD_WRITE_CFG) begin
                ack_next = ~busy_reg;                       // [R17]
              end
            end
            2'd2: begin
              if (cmd_reg == `BCC_CMD_SET_PTR && ptr_code_ok(shift_reg)) begin
                ack_next = 1'b1;                            // [R11]
                act_next = ACT_PTR;
              end else if (cmd_reg == `BCC_CMD_WRITE_CFG) begin
                ack_next = 1'b1;
                act_next = cfg_code_ok(shift_reg) ? ACT_CFG : ACT_NONE;  // [R15]
              end
            end
            default: begin
              ack_next = 1'b0;
            end
          endcase
          sda_oe_next = ack_next;
          state_next  = ST_ACK;
        end
      end
      ST_ACK: begin
        if (scl_rise) begin
          // Pointer and setup commit on the rising edge of the ack bit
          if (act_reg == ACT_PTR) begin
            ptr_next = shift_reg;                           // [R9] [R10] [R12]
          end else if (act_reg == ACT_CFG) begin
            setup_next  = shift_reg[3:0];                   // [R14] [R19] [R21]
            rstflg_next = 1'b0;                             // [R21]
            ptr_next    = `BCC_OFS_SETUP;                   // [R20]
          end
          if (act_reg != ACT_GRST) begin
            act_next = ACT_NONE;
          end
        end else if (scl_fall) begin
          bitcnt_next = 4'd0;
          bidx_next   = (bidx_reg == 2'd3) ? 2'd3 : bidx_reg + 2'd1;
          if (act_reg == ACT_GRST) begin
            // Lands one cycle after the ack's falling edge, inside both bounds
            abort_next  = 1'b1;                             // [R1] [R2] [R3]
            flags_next  = '0;                               // [R5]
            busy_next   = 1'b0;                             // [R5]
            rstflg_next = 1'b1;                             // [R5]
            setup_next  = `BCC_SETUP_RST;                   // [R6]
            ptr_next    = `BCC_OFS_FLAGS;                   // [R4]
            act_next    = ACT_NONE;
            bidx_next   = 2'd3;                             // [R2]
          end
          if (!ack_reg) begin
            sda_oe_next = 1'b0;
            state_next  = ST_IDLE;
          end else if (rd_reg && bidx_reg == 2'd0) begin
            shift_next  = rdata;
            sda_oe_next = ~rdata[7];
            state_next  = ST_TX;
          end else begin
            sda_oe_next = 1'b0;
            state_next  = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (bitcnt_reg == 4'd7) begin
            sda_oe_next = 1'b0;
            state_next  = ST_MACK;
          end else begin
            shift_next  = {shift_reg[6:0], 1'b0};
            bitcnt_next = bitcnt_reg + 4'd1;
            sda_oe_next = ~shift_reg[6];
          end
        end
      end
      ST_MACK: begin
        if (scl_rise && sda_in) begin
          state_next = ST_IDLE;
        end else if (scl_fall) begin
          // Host asked for more: repeat the same register
          shift_next  = rdata;
          bitcnt_next = 4'd0;
          sda_oe_next = ~rdata[7];
          state_next  = ST_TX;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // A start or stop ends any transfer, even mid-byte
    if (bus_start) begin
      state_next  = ST_RX;
      bitcnt_next = 4'd0;
      bidx_next   = 2'd0;
      act_next    = ACT_NONE;
      sda_oe_next = 1'b0;
    end else if (bus_stop) begin
      state_next  = ST_IDLE;
      act_next    = ACT_NONE;
      sda_oe_next = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      act_reg    <= ACT_NONE;
      shift_reg  <= 8'h00;
      bitcnt_reg <= 4'h0;
      bidx_reg   <= 2'h0;
      cmd_reg    <= 8'h00;
      rd_reg     <= 1'b0;
      ack_reg    <= 1'b0;
      ptr_reg    <= `BCC_OFS_FLAGS;
      setup_reg  <= `BCC_SETUP_RST;
      flags_reg  <= '0;
      rstflg_reg <= `BCC_RSTFLAG_RST;
      busy_reg   <= 1'b0;
      abort_reg  <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      act_reg    <= act_next;
      shift_reg  <= shift_next;
      bitcnt_reg <= bitcnt_next;
      bidx_reg   <= bidx_next;
      cmd_reg    <= cmd_next;
      rd_reg     <= rd_next;
      ack_reg    <= ack_next;
      ptr_reg    <= ptr_next;
      setup_reg  <= setup_next;
      flags_reg  <= flags_next;
      rstflg_reg <= rstflg_next;
      busy_reg   <= busy_next;
      abort_reg  <= abort_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Open drain: only ever pull low
  assign sda_out       = 1'b0;
  assign sda_oe        = sda_oe_reg;
  assign setup         = setup_reg;                       // [R14]
  assign bus_abort     = abort_reg;                       // [R1] [R3]
  // Engine reloads its port defaults on the same pulse; also high in reset
  assign port_defaults = abort_reg | ~rst_n;              // [R7]

endmodule

// file: verilog/bcc_consts.svh
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// Command codes
`define BCC_CMD_DEV_RESET   8'hf0
`define BCC_CMD_SET_PTR     8'he1
`define BCC_CMD_WRITE_CFG   8'hd2

// Register offsets, also the valid pointer codes
`define BCC_OFS_PORT        8'hb4
`define BCC_OFS_SETUP       8'hc3
`define BCC_OFS_RXBYTE      8'he1
`define BCC_OFS_FLAGS       8'hf0

// Status register field positions
`define BCC_FL_BUSY         0
`define BCC_FL_PPD          1
`define BCC_FL_SD           2
`define BCC_FL_LL           3
`define BCC_FL_RST          4
`define BCC_FL_SBR          5
`define BCC_FL_TSB          6
`define BCC_FL_DIR          7

// Configuration byte field positions (low nibble)
`define BCC_CF_APU          0
`define BCC_CF_PDN          1
`define BCC_CF_SPU          2
`define BCC_CF_SPEED        3

// Reset values
`define BCC_SETUP_RST       4'h0
`define BCC_RSTFLAG_RST     1'b1
`define BCC_SLAVE_ADDR      7'h18

// Timing of the global reset, in picoseconds, and the clock period
`define BCC_GRST_MAX_PS     525000
`define BCC_BUSSTOP_MAX_PS  262500
`define BCC_CLK_PS          20000

`endif

// file: verilog/bcc_pkg.sv
package bcc_pkg;

  // Device setup bits
  typedef struct packed {
    logic bus_speed_select;
    logic strong_pullup_enable;
    logic bus_power_down;
    logic active_pullup_enable;
  } bcc_setup_t;

  // Result flags delivered by the bus engine
  typedef struct packed {
    logic branch_dir;
    logic triplet_second_bit;
    logic single_bit_result;
    logic short_seen_flag;
    logic presence_seen_flag;
  } bcc_eng_flags_t;

  // Serial slave states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_MACK = 5'b10000
  } bcc_state_t;

  // Action armed by an acknowledged byte
  typedef enum logic [3:0] {
    ACT_NONE = 4'b0001,
    ACT_GRST = 4'b0010,
    ACT_PTR  = 4'b0100,
    ACT_CFG  = 4'b1000
  } bcc_act_t;

endpackage

// file: verification/bcc_top_properties.sv
`timescale 1ns/1ps
module bcc_top_properties
  import bcc_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // Watched pins
  input wire logic       scl,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       eng_busy,
  input wire bcc_setup_t setup,
  input wire logic       bus_abort,
  input wire logic       port_defaults
);
  logic [7:0] busy_cnt_reg;
  logic [7:0] busy_cnt_next;

  // Run length of engine busy; saturates so a long stall never wraps
  always_comb begin
    busy_cnt_next = busy_cnt_reg + 8'h01;
    if (!eng_busy) begin
      busy_cnt_next = 8'h00;
    end else if (busy_cnt_reg == 8'hff) begin
      busy_cnt_next = busy_cnt_reg;
    end
  end

  // Counter register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_abort_once;
    bus_abort ##1 !bus_abort;
  endsequence

  property p_abort_pulse;    bus_abort |-> s_abort_once; endproperty
  property p_abort_dflt;     bus_abort |-> port_defaults; endproperty
  property p_abort_clear;    bus_abort |-> (setup == 4'h0); endproperty
  // Abort must follow the ack's falling clock within two cycles, far inside the bound
  property p_abort_scl_low;  bus_abort |-> (!scl && $past(scl, 2)); endproperty
  property p_sda_low;        sda_out == 1'b0; endproperty
  property p_oe_scl_low;     $changed(sda_oe) |-> !scl; endproperty
  property p_setup_scl_high; ($changed(setup) && !bus_abort) |-> scl; endproperty
  // A long busy run means the flag was set when the command arrived
  property p_busy_hold;      (busy_cnt_reg == 8'hff && !bus_abort) |-> $stable(setup); endproperty

  a_abort_pulse: assert property (p_abort_pulse)
    else $error("abort pulse too long");
  a_abort_dflt: assert property (p_abort_dflt)
    else $error("port defaults missing on abort");
  a_abort_clear: assert property (p_abort_clear)
    else $error("setup not cleared by reset command");
  a_abort_scl_low: assert property (p_abort_scl_low)
    else $error("reset command acted late or outside ack low phase");
  a_sda_low: assert property (p_sda_low)
    else $error("data output not low");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed while clock high");
  a_setup_scl_high: assert property (p_setup_scl_high)
    else $error("setup changed off the ack rising edge");
  a_busy_hold: assert property (p_busy_hold)
    else $error("setup written while busy");
endmodule

// file: verification/bcc_host_model.sv
`timescale 1ns/1ps
module bcc_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  input wire logic sda_line,
  output logic     scl,
  output logic     sda_drv
);
  // Idle bus: both lines released high by the pull-ups
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Half of a bit, changes land off the sampling edge
  task automatic hp();
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic start();
    sda_drv = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b0;
    hp();
    scl = 1'b0;
    hp();
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b1;
    hp();
  endtask

  // One bit; the line is read at the end of the high phase, just before SCL falls
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_line;
    scl = 1'b0;
  endtask

  // Byte MSB first, then the ninth bit with the line released
  task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r[i]);
    end
    bit_x(1'b1, a);
    ack = ~a;
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import bcc_pkg::*;
  localparam logic [6:0] ADDR = 7'h18;
  logic           sys_clk, rstn, scl, host_sda, sda_out, sda_oe, bus_abort, port_defaults;
  logic           eng_busy, eng_line_level, eng_flags_we, eng_ptr_to_flags, a0, a1, abort_seen;
  logic           busy_want;
  logic [3:0]     eng_port_code, n;
  logic [7:0]     eng_rx_byte, d, p;
  logic [31:0]    lfsr, r;
  bcc_eng_flags_t eng_flags, fl;
  bcc_setup_t     setup;
  int             bad_count, n_checks;
  logic [7:0]     codes [4] = '{8'hb4, 8'hc3, 8'he1, 8'hf0};
  wire            sda_line = host_sda & ~sda_oe;

  bcc_top #(.SLAVE_ADDR(ADDR)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .eng_busy(eng_busy),
    .eng_line_level(eng_line_level), .eng_flags_we(eng_flags_we), .eng_flags(eng_flags),
    .eng_ptr_to_flags(eng_ptr_to_flags), .eng_rx_byte(eng_rx_byte),
    .eng_port_code(eng_port_code), .setup(setup), .bus_abort(bus_abort),
    .port_defaults(port_defaults));
  bcc_host_model host_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Engine stand-in: busy drops once an abort is seen, as the real engine must
  always @(negedge sys_clk) begin
    abort_seen <= rstn & (abort_seen | bus_abort);
  end
  assign eng_busy = busy_want & ~abort_seen;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Status byte expected from latched flags and live line level
  function automatic logic [7:0] st(input logic rst, input logic busy);
    return {fl.branch_dir, fl.triplet_second_bit, fl.single_bit_result, rst,
            eng_line_level, fl.short_seen_flag, fl.presence_seen_flag, busy};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Command and optional parameter in one write transfer
  task automatic wr(input logic [7:0] c, input logic [7:0] pr, input logic two);
    logic [7:0] q;
    logic ad;
    host_u.start();
    host_u.xfer({ADDR, 1'b0}, q, ad);
    check({7'h0, ad}, 8'h01);
    host_u.xfer(c, q, a0);
    a1 = 1'b0;
    if (two) begin
      host_u.xfer(pr, q, a1);
    end
    host_u.stop();
  endtask

  task automatic rd(output logic [7:0] q);
    logic ad;
    logic [7:0] x;
    host_u.start();
    host_u.xfer({ADDR, 1'b1}, x, ad);
    check({7'h0, ad}, 8'h01);
    host_u.xfer(8'hff, q, ad);
    host_u.stop();
  endtask

  task automatic rdp(input logic [7:0] ptr, input logic [7:0] exp);
    wr(8'he1, ptr, 1'b1);
    check({6'h0, a0, a1}, 8'h03);
    rd(d);
    check(d, exp);
  endtask

  initial begin
    lfsr = 32'h81ed972b;
    {bad_count, n_checks} = '0;
    {rstn, busy_want, eng_line_level, eng_flags_we, eng_ptr_to_flags} = '0;
    {eng_flags, fl, eng_rx_byte, eng_port_code} = '0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(d);
    check(d, st(1'b1, 1'b0));
    // Random engine results
    r = rnd();
    eng_rx_byte = r[7:0];
    eng_flags = r[12:8];
    eng_port_code = r[19:16];
    eng_line_level = r[20];
    eng_flags_we = 1'b1;
    @(negedge sys_clk) eng_flags_we = 1'b0;
    fl = eng_flags;
    // Setup writes, boundary nibbles first
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      n = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : r[3:0];
      wr(8'hd2, {~n, n}, 1'b1);
      check({6'h0, a0, a1}, 8'h03);
      check({4'h0, setup}, {4'h0, n});
      rd(d);
      check(d, {4'h0, n});
    end
    rdp(8'hf0, st(1'b0, 1'b0));
    wr(8'hd2, 8'h55, 1'b1);
    check({4'h0, setup}, {4'h0, n});
    for (int i = 0; i < 4; i++) begin
      rdp(codes[i], (i == 0) ? {4'h0, eng_port_code} : (i == 1) ? {4'h0, n} :
          (i == 2) ? eng_rx_byte : st(1'b0, 1'b0));
    end
    // Park the pointer off the status register so a wrong accept would show
    rdp(8'hc3, {4'h0, n});
    r = rnd();
    p = (r[7:0] inside {8'hb4, 8'hc3, 8'he1, 8'hf0}) ? 8'h5a : r[7:0];
    wr(8'he1, p, 1'b1);
    check({7'h0, a1}, 8'h00);
    rd(d);
    check(d, {4'h0, n});
    // Engine busy: setup write refused, pointer still free
    @(negedge sys_clk) busy_want = 1'b1;
    repeat (300) @(negedge sys_clk);
    wr(8'hd2, {n, ~n}, 1'b1);
    check({6'h0, a0, a1}, 8'h00);
    check({4'h0, setup}, {4'h0, n});
    // Engine moves the pointer to the flags; a later host set still wins
    eng_ptr_to_flags = 1'b1;
    @(negedge sys_clk) eng_ptr_to_flags = 1'b0;
    rd(d);
    check(d, st(1'b0, 1'b1));
    rdp(8'hf0, st(1'b0, 1'b1));
    rdp(8'hc3, {4'h0, n});
    // Global reset in mid activity
    wr(8'hf0, 8'h00, 1'b0);
    check({7'h0, a0}, 8'h01);
    check({7'h0, abort_seen}, 8'h01);
    check({4'h0, setup}, 8'h00);
    fl = '0;
    rd(d);
    check(d, st(1'b1, 1'b0));
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule

bind bcc_top bcc_top_properties chk_u (.sys_clk(sys_clk), .rstn(rstn), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe), .eng_busy(eng_busy), .setup(setup),
  .bus_abort(bus_abort), .port_defaults(port_defaults));
